// ===== logic/sarcc_ctrl.sv
/*
 * Conversion sequencer and read interface of an 8-bit successive
 * approximation converter. Assumes the comparator output, the converter
 * clock pin and the host strobes are all synchronous to MCLK and that the
 * tri-state result pins are resolved outside from RESULT_BUS_OE.
 */
module sarcc_ctrl
	import sarcc_pkg::*;
(
	input  wire logic                  MCLK,
	input  wire logic                  RST,
	input  wire logic                  CS_N,
	input  wire logic                  RD_N,
	input  wire logic                  CLK_PIN,
	input  wire logic                  MODE,
	input  wire logic                  MULTI_SAMPLE,
	input  wire logic                  COMP_ABOVE,
	output logic                       BUSY_N,
	output logic [sarcc_pkg::RES_W-1:0] TRIAL_CODE,
	output logic                       HOLD,
	output logic                       SAMPLE,
	output logic [sarcc_pkg::RES_W-1:0] RESULT_BUS_O,
	output logic                       RESULT_BUS_OE
);

	typedef struct packed {
		sarcc_state_e     st;
		logic [4:0]       edges;
		logic             clk_prev;
		logic             busy_n;
		logic             hold;
		logic             sample;
		logic             armed;
		logic             window;
		logic             pend;
		logic [RES_W-1:0] done_code;
		logic [RES_W-1:0] latch;
		logic             oe;
	} sarcc_ctrl_s;

	sarcc_ctrl_s s;
	sarcc_ctrl_s next_s;

	logic             rd_act;
	logic             fall;
	logic             cont;
	logic             start;
	logic             done;
	logic             load_half;
	logic             decide;
	logic [4:0]       ne;
	logic [RES_W-1:0] code;

	// ----------------------------------------------------------------
	// decoded inputs
	// ----------------------------------------------------------------
	assign rd_act = !CS_N && !RD_N; // R22
	assign fall   = s.clk_prev && !CLK_PIN;
	assign cont   = MULTI_SAMPLE && !MODE;
	assign ne     = 5'(s.edges + 5'h01);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s          = s;
		next_s.clk_prev = CLK_PIN;
		next_s.sample   = 1'b0;
		next_s.oe       = rd_act; // R23
		start           = 1'b0;
		done            = 1'b0;
		load_half       = 1'b0;
		decide          = 1'b0;
		if (!rd_act) begin
			next_s.armed = 1'b1;
		end
		if (s.window && fall) begin
			next_s.window = 1'b0;
		end
		// a result held back by a read goes out once the read is over
		if (s.pend && !rd_act) begin
			next_s.latch = s.done_code; // R14
			next_s.pend  = 1'b0;
		end
		unique case (s.st)
			SARCC_IDLE: begin
				if (cont) begin
					start = !rd_act; // R13 R15
				end else begin
					start = rd_act && s.armed && !s.window; // R10
					if (rd_act && s.window) begin
						next_s.armed = 1'b0; // R11
					end
				end
				if (start) begin
					next_s.st     = SARCC_CONV;
					next_s.edges  = 5'h00;
					next_s.busy_n = 1'b0; // R7
					next_s.hold   = 1'b0;
					if (rd_act) begin
						next_s.armed = 1'b0;
					end
				end
			end
			SARCC_CONV: begin
				// the pin clock only counts while converting
				if (fall) begin // R21
					next_s.edges = ne; // R20
					if (!MULTI_SAMPLE && (ne == EDGE_HOLD)) begin
						next_s.hold = 1'b1; // R5
					end
					if (MULTI_SAMPLE && ne[0] && (ne >= EDGE_HOLD)
						&& (ne <= EDGE_LAST_SMP)) begin
						next_s.sample = 1'b1; // R6
					end
					if (!ne[0] && (ne >= EDGE_FIRST_DEC)
						&& (ne <= EDGE_LAST_DEC)) begin
						decide = 1'b1; // R1 R2
					end
					if (ne == EDGE_DONE) begin
						done             = 1'b1;
						load_half        = 1'b1; // R4
						next_s.st        = SARCC_IDLE;
						next_s.busy_n    = 1'b1; // R4
						next_s.hold      = 1'b0;
						next_s.window    = !cont;
						next_s.done_code = code;
						if (cont && rd_act) begin
							next_s.pend = 1'b1; // R14
						end else begin
							next_s.latch = code; // R3 R8 R9 R16
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s.st        <= SARCC_IDLE;
			s.edges     <= 5'h00;
			s.clk_prev  <= 1'b0;
			s.busy_n    <= 1'b1;
			s.hold      <= 1'b0;
			s.sample    <= 1'b0;
			s.armed     <= 1'b0;
			s.window    <= 1'b0;
			s.pend      <= 1'b0;
			s.done_code <= RESULT_RST;
			s.latch     <= RESULT_RST;
			s.oe        <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	sarcc_sar u_sar (
		.clk       (MCLK),
		.rst       (RST),
		.load_half (load_half),
		.decide    (decide),
		.above     (COMP_ABOVE),
		.code      (code)
	);

	assign BUSY_N        = s.busy_n;
	assign TRIAL_CODE    = code;
	assign HOLD          = s.hold;
	assign SAMPLE        = s.sample;
	assign RESULT_BUS_O  = s.latch;
	assign RESULT_BUS_OE = s.oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [4:0] chk_falls;
	logic [3:0] chk_samples;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			chk_falls   <= 5'h00;
			chk_samples <= 4'h0;
		end else if (start) begin
			chk_falls   <= 5'h00;
			chk_samples <= 4'h0;
		end else begin
			if (!s.busy_n && fall) begin
				chk_falls <= 5'(chk_falls + 5'h01);
			end
			if (s.sample) begin
				chk_samples <= 4'(chk_samples + 4'h1);
			end
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	property p_start_busy;
		start |=> !BUSY_N ##1 !BUSY_N;
	endproperty
	a_start_busy: assert property (p_start_busy) // R7
		else $error("busy did not go low after start");

	property p_keep_bit;
		decide && COMP_ABOVE
			|=> (TRIAL_CODE & $past(TRIAL_CODE)) == $past(TRIAL_CODE);
	endproperty
	a_keep_bit: assert property (p_keep_bit) // R1
		else $error("trial bit dropped although input was above");

	property p_drop_bit;
		decide && !COMP_ABOVE |=> TRIAL_CODE < $past(TRIAL_CODE);
	endproperty
	a_drop_bit: assert property (p_drop_bit) // R2
		else $error("trial bit kept although input was below");

	property p_latch_result;
		done && !cont |=> RESULT_BUS_O == $past(code) && BUSY_N;
	endproperty
	a_latch_result: assert property (p_latch_result) // R3
		else $error("result latch not loaded at conversion end");

	property p_half_at_end;
		$rose(BUSY_N) |-> TRIAL_CODE == HALF_SCALE
			&& chk_falls == EDGE_DONE;
	endproperty
	a_half_at_end: assert property (p_half_at_end) // R4
		else $error("end of conversion without half scale or 20 edges");

	property p_hold_edge;
		$rose(HOLD) |-> s.edges == EDGE_HOLD && !MULTI_SAMPLE;
	endproperty
	a_hold_edge: assert property (p_hold_edge) // R5
		else $error("hold not on third falling edge");

	property p_eight_samples;
		done && MULTI_SAMPLE |-> chk_samples == SAMPLES_PER_CONV;
	endproperty
	a_eight_samples: assert property (p_eight_samples) // R6
		else $error("sample count per conversion is not eight");

	property p_window_read;
		s.st == SARCC_IDLE && s.window && rd_act && !cont
			|=> BUSY_N ##1 BUSY_N;
	endproperty
	a_window_read: assert property (p_window_read) // R11
		else $error("read right after end started a conversion");

	property p_cont_stall;
		s.st == SARCC_IDLE && cont && rd_act |=> BUSY_N;
	endproperty
	a_cont_stall: assert property (p_cont_stall) // R15
		else $error("continuous mode converted during a read");

	property p_pend_release;
		s.pend && !rd_act |=> RESULT_BUS_O == $past(s.done_code) && !s.pend;
	endproperty
	a_pend_release: assert property (p_pend_release) // R14
		else $error("held back result not released");

	property p_old_data;
		!BUSY_N && $past(!BUSY_N) && !cont |-> $stable(RESULT_BUS_O);
	endproperty
	a_old_data: assert property (p_old_data) // R16
		else $error("result changed during conversion");

	property p_drive;
		RESULT_BUS_OE |-> $past(!CS_N && !RD_N);
	endproperty
	a_drive: assert property (p_drive) // R22
		else $error("result driven without chip select and read");

	c_sync_done: cover property (done && !cont && rd_act);
	c_cont_pend: cover property (done && cont && rd_act);
	c_window: cover property (s.window && rd_act && s.st == SARCC_IDLE);
	c_multi: cover property (done && MULTI_SAMPLE);

endmodule // sarcc_ctrl

// ===== logic/sarcc_pkg.sv
/*
 * Constants and types shared by the conversion controller and its
 * approximation register. Assumes one 10 MHz system clock (MCLK) and a
 * converter clock pin that is sampled as a plain synchronous input.
 */
// Operation
// R1 - trial starts at half scale; MSB kept only when comparator says above
// R2 - each decision stores the bit, picks next trial bit, shows code to DAC
// R3 - after eight decisions the approximation is copied to the result latch
// R4 - at conversion end busy goes high, result readable, DAC back to half
// R5 - single-sample variant holds input on third falling clock after read
// R6 - multi-sample variant samples input before every one of eight decisions
// R7 - a conversion started by a read drives busy low
// R8 - slow-memory host holds read low through conversion; result latched at end
// R9 - slow-memory end updates latch and drivers so pending read gets new data
// R10 - ROM-style read returns old result and starts a new conversion
// R11 - read within one clock period after busy rises reads, starts nothing
// R12 - ROM-style host must not read while busy is low
// R13 - continuous mode converts by itself; reads never start conversions
// R14 - continuous mode updates latch at busy rise, or after read ends
// R15 - continuous mode stalls with busy high while a read is active
// R16 - read during conversion returns previous result intact
// R17 - host avoids read edges within 20ns of a falling converter clock
// R18 - host starts conversions at equal intervals for equal sample spacing
// R19 - slow-memory host must stretch reads at least 10us
// R20 - converter clock halved inside; one conversion is 20 pin cycles
// R21 - converter clock ignored outside a conversion
// R22 - read strobe counts only while chip select is low
// R23 - result outputs driven only while chip select and read are low; RESULT_BUS_OE is registered and follows them one MCLK later
package sarcc_pkg;

	// ----------------------------------------------------------------
	// widths and values
	// ----------------------------------------------------------------
	localparam int         RES_W      = 8;
	localparam logic [7:0] HALF_SCALE = 8'h80;
	localparam logic [7:0] RESULT_RST = 8'h00;

	// ----------------------------------------------------------------
	// falling-edge counts of the converter clock pin within a conversion, and samples per conversion
	// ----------------------------------------------------------------
	localparam logic [4:0] EDGE_HOLD     = 5'h03;
	localparam logic [4:0] EDGE_LAST_SMP = 5'h11;
	localparam logic [4:0] EDGE_FIRST_DEC = 5'h04;
	localparam logic [4:0] EDGE_LAST_DEC = 5'h12;
	localparam logic [4:0] EDGE_DONE     = 5'h14;
	localparam logic [3:0] SAMPLES_PER_CONV = 4'h8;

	typedef enum logic [0:0] {
		SARCC_IDLE,
		SARCC_CONV
	} sarcc_state_e;

endpackage

// ===== logic/sarcc_sar.sv
/*
 * Successive-approximation register: trial code for the DAC and the
 * one-hot pointer to the bit under trial. Assumes the controller pulses
 * load_half and decide for one cycle each and never both at once.
 */
module sarcc_sar
	import sarcc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             load_half,
	input  wire logic             decide,
	input  wire logic             above,
	output logic [sarcc_pkg::RES_W-1:0] code
);

	typedef struct packed {
		logic [RES_W-1:0] code;
		logic [RES_W-1:0] mask;
	} sarcc_sar_s;

	sarcc_sar_s s;
	sarcc_sar_s next_s;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		if (load_half) begin
			next_s.code = HALF_SCALE; // R4
			next_s.mask = HALF_SCALE;
		end else if (decide && (s.mask != '0)) begin
			// keep the bit under trial only when the input is above it
			next_s.mask = s.mask >> 1; // R2
			next_s.code = (above ? s.code : (s.code & ~s.mask))
				| (s.mask >> 1); // R1 R2
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s.code <= HALF_SCALE;
			s.mask <= HALF_SCALE;
		end else begin
			s <= next_s;
		end
	end

	assign code = s.code;

endmodule // sarcc_sar

// ===== test/sarcc_host.sv
/*
 * Far-side model: host strobes, free-running converter clock and the
 * comparator. Assumes the bench calls bus() from its main thread.
 */
module sarcc_host (
	input  wire logic       clk,
	input  wire logic [7:0] trial,
	output logic            cs_n,
	output logic            rd_n,
	output logic            clk_pin,
	output logic            above
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div;
	logic [7:0] ain;
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		div = 2'h0;
		ain = 8'h00;
	end
	// pin clock derived from MCLK so starts keep equal spacing
	always @(posedge clk) begin
		div <= div + 2'h1;
	end
	assign clk_pin = div[1];
	// input sits half an LSB above ain, so a tie counts as above
	assign above = ain >= trial;
	// strobes move on MCLK rises, never on the rise that makes a pin fall
	task bus(input logic cs, input logic rd);
		@(posedge clk);
		while (div == 2'h3) @(posedge clk);
		cs_n <= cs;
		rd_n <= rd;
	endtask
endmodule // sarcc_host

// ===== test/sarcc_ctrl_test.sv
/*
 * Self-checking bench: reset, table of slow-memory conversions, then
 * ROM-style, deselect, continuous and mid-run reset cases.
 * Assumes sarcc_host.
 */
module sarcc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import sarcc_pkg::*;
	typedef struct packed {
		logic       multi;
		logic [7:0] ain;
		logic [7:0] want;
	} sarcc_row_s;
	localparam sarcc_row_s ROWS [6] = '{
		'{1'b0, 8'h00, 8'h00}, '{1'b0, 8'hff, 8'hff},
		'{1'b1, 8'h80, 8'h80}, '{1'b1, 8'h7f, 8'h7f},
		'{1'b0, 8'ha5, 8'ha5}, '{1'b1, 8'h01, 8'h01}};
	logic       mclk, rst, mode, multi, cs_n, rd_n, clk_pin, above;
	logic       busy_n, hold, sample, oe, pv;
	logic [7:0] trial, res;
	logic [4:0] nfall, hold_at;
	logic [3:0] nsmp;
	int         errors, compares;

	sarcc_host host (.clk(mclk), .trial(trial), .cs_n(cs_n),
		.rd_n(rd_n), .clk_pin(clk_pin), .above(above));
	sarcc_ctrl dut (.MCLK(mclk), .RST(rst), .CS_N(cs_n), .RD_N(rd_n),
		.CLK_PIN(clk_pin), .MODE(mode), .MULTI_SAMPLE(multi),
		.COMP_ABOVE(above), .BUSY_N(busy_n), .TRIAL_CODE(trial),
		.HOLD(hold), .SAMPLE(sample), .RESULT_BUS_O(res),
		.RESULT_BUS_OE(oe));

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		mode = 1'b1;
		multi = 1'b0;
		pv = 1'b0;
		errors = 0;
		compares = 0;
	end
	always #50 mclk = ~mclk;

	// falls, sample pulses and hold instant, seen as the design sees them
	always @(posedge mclk) begin
		pv <= clk_pin;
		if (busy_n === 1'b0 && pv && !clk_pin) nfall <= nfall + 5'h1;
		if (sample === 1'b1) nsmp <= nsmp + 4'h1;
		if (hold === 1'b1 && hold_at === 5'h0) hold_at <= nfall;
	end

	task check(input logic [7:0] seen, input logic [7:0] want);
		compares++;
		if (seen !== want) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	// host in a wait state; 200 cycles is 20us of stretch
	task wait_busy(input logic lvl);
		repeat (200) if (busy_n !== lvl) @(negedge mclk);
		check({7'h00, busy_n}, {7'h00, lvl});
	endtask
	task close_out;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#1ms;
		errors++;
		close_out();
	end

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		check({busy_n, hold, sample, oe, 4'h0}, 8'h80);
		check(trial, HALF_SCALE);
		check(res, RESULT_RST);
		foreach (ROWS[i]) begin
			@(posedge mclk);
			multi <= ROWS[i].multi;
			host.ain <= ROWS[i].ain;
			@(negedge mclk);
			nfall = 5'h0;
			nsmp = 4'h0;
			hold_at = 5'h0;
			host.bus(1'b0, 1'b0);
			wait_busy(1'b0);
			check(trial, HALF_SCALE);
			wait_busy(1'b1);
			check(res, ROWS[i].want);
			check({7'h00, oe}, 8'h01);
			check(trial, HALF_SCALE);
			check({3'h0, nfall}, 8'h14);
			check({4'h0, nsmp}, ROWS[i].multi ? 8'h08 : 8'h00);
			check({3'h0, hold_at}, ROWS[i].multi ? 8'h00 : 8'h03);
			host.bus(1'b1, 1'b1);
			repeat (6) @(negedge mclk);
		end
		// short read: old data out, new conversion started
		@(posedge mclk);
		multi <= 1'b0;
		host.ain <= 8'h3c;
		@(negedge mclk);
		nfall = 5'h0;
		host.bus(1'b0, 1'b0);
		repeat (2) @(negedge mclk);
		check(res, 8'h01);
		check({7'h00, busy_n}, 8'h00);
		check({7'h00, oe}, 8'h01);
		host.bus(1'b1, 1'b1);
		repeat (200) if (nfall !== 5'h14) @(negedge mclk);
		check({3'h0, nfall}, 8'h14);
		// read lands one MCLK after busy rises, inside the window
		host.bus(1'b0, 1'b0);
		repeat (8) @(negedge mclk);
		check({7'h00, busy_n}, 8'h01);
		check(res, 8'h3c);
		host.bus(1'b1, 1'b1);
		repeat (4) @(negedge mclk);
		host.bus(1'b1, 1'b0);
		repeat (8) @(negedge mclk);
		check({busy_n, oe, 6'h00}, 8'h80);
		host.bus(1'b1, 1'b1);
		@(posedge mclk);
		host.ain <= 8'h5a;
		multi <= 1'b1;
		mode <= 1'b0;
		wait_busy(1'b0);
		wait_busy(1'b1);
		check(res, 8'h5a);
		@(posedge mclk);
		host.ain <= 8'hc3;
		wait_busy(1'b0);
		host.bus(1'b0, 1'b0);
		repeat (2) @(negedge mclk);
		check(res, 8'h5a);
		wait_busy(1'b1);
		repeat (6) @(negedge mclk);
		check({7'h00, busy_n}, 8'h01);
		check(res, 8'h5a);
		host.bus(1'b1, 1'b1);
		repeat (2) @(negedge mclk);
		check({7'h00, busy_n}, 8'h00);
		check(res, 8'hc3);
		// reset in mid conversion: idle values at once, restart after
		@(posedge mclk);
		rst <= 1'b1;
		@(negedge mclk);
		check({busy_n, hold, sample, oe, 4'h0}, 8'h80);
		check(trial, HALF_SCALE);
		check(res, RESULT_RST);
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		wait_busy(1'b0);
		check(res, RESULT_RST);
		close_out();
	end
endmodule // sarcc_ctrl_test
